//--- hw/shs_regs.svh
`ifndef SHS_REGS_SVH
`define SHS_REGS_SVH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SHS_SETTLE_ADDR 16'hfffa
`define SHS_SETTLE_RESET 3'h4
`define SHS_SETTLE_CODE_MAX 3'h4
`define SHS_SETTLE_CODE_LSB 0
`define SHS_SETTLE_CODE_W 3
// ----------------------------------------------------------------
// Settle exponents (wait is 2^exp main clock periods)
// ----------------------------------------------------------------
`define SHS_EXP_CODE0 5'd12
`define SHS_EXP_CODE1 5'd14
`define SHS_EXP_CODE2 5'd15
`define SHS_EXP_CODE3 5'd16
`define SHS_EXP_CODE4 5'd17
`define SHS_EXP_SLOW_ADD 5'd1
`define SHS_EXP_RESET 5'd17
// ----------------------------------------------------------------
// Light-mode release waits, in clocks
// ----------------------------------------------------------------
`define SHS_HALT_VEC_WAIT 4'd8
`define SHS_HALT_NEXT_WAIT 4'd2
`endif

//--- hw/shs_pkg.sv
package shs_pkg;
  // Controller states, one-hot
  typedef enum logic [5:0] {
    SHS_RST_SETTLE = 6'h01,
    SHS_RUN = 6'h02,
    SHS_HALT = 6'h04,
    SHS_STOP = 6'h08,
    SHS_SETTLE = 6'h10,
    SHS_RESUME = 6'h20
  } shs_state_type;
endpackage

//--- hw/shs_settle_counter.sv
`timescale 1ns/1ns
`default_nettype none
module shs_settle_counter #(
  parameter int CNT_W = 19
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic osc_run_i,
  input wire logic [4:0] exp_i,
  output logic done_o
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > 31) begin : g_chk
    $error("shs_settle_counter: CNT_W out of range");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] term_m1;

  // Terminal value is 2^exp - 1, so the count spans 2^exp cycles
  assign term_m1 = CNT_W'((32'h1 << exp_i) - 32'h1);

  // Counts only while the oscillator runs; start clears it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else if (start_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else if (osc_run_i && !done_o) begin
      if (cnt == term_m1) begin
        done_o <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/shs_standby_ctrl.sv
// Contract
// - Halt instruction gates the processor clock; oscillators run on.
// - Stop instruction halts the main oscillator and everything on it.
// - Standby entry keeps registers, flags, memory and port latches.
// - Deep mode only from main clock; light mode from either clock.
// - Deep mode never stops the subsystem oscillator.
// - An interrupt request releases the deep mode.
// - Settle select register sets wait after interrupt release.
// - Reset loads settle code selecting the longest listed wait.
// - Reset release of deep mode waits 2^17 main clock periods.
// - Code 0..4 picks 2^12,14,15,16,17, one higher if mode bit clear.
// - Settle count starts only once the oscillator runs.
// - Main halt without subclock: watch and display need divided clock.
// - Subclock halt, main stopped: 8-bit timers need external input.
// - Subclock halt, main stopped: 16-bit timer needs subclock watch.
// - Subclock halt, main stopped: serial needs external clock.
// - Unmasked interrupt releases light mode; vector if enabled.
// - Light release waits 8 clocks for vector, 2 for next.
// - Test input releases either mode, resumes at next instruction.
`timescale 1ns/1ns
`default_nettype none
`include "shs_regs.svh"
module shs_standby_ctrl
  import shs_pkg::*;
#(
  parameter int CNT_W = 19,
  parameter int SETTLE_EXP_CUT = 0
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_bit_op_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic halt_exec_i,
  input wire logic stop_exec_i,
  input wire logic on_subclock_i,
  input wire logic main_osc_off_i,
  input wire logic sub_clk_present_i,
  input wire logic osc_mode_bit_i,
  input wire logic osc_running_i,
  input wire logic irq_pending_i,
  input wire logic nmi_pending_i,
  input wire logic irq_enable_i,
  input wire logic test_input_i,
  input wire logic wt_clk_main_div_i,
  input wire logic wt_clk_sub_i,
  input wire logic tmr8_ext_clk_i,
  input wire logic tmr16_wt_clk_i,
  input wire logic sio_ext_clk_i,
  output logic cpu_clk_en_o,
  output logic main_osc_en_o,
  output logic sub_osc_en_o,
  output logic reset_hold_o,
  output logic standby_o,
  output logic resume_vector_o,
  output logic resume_next_o,
  output logic wt_run_o,
  output logic lcd_run_o,
  output logic tmr8_run_o,
  output logic tmr16_run_o,
  output logic sio_run_o
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (SETTLE_EXP_CUT < 0 || SETTLE_EXP_CUT > 11 || CNT_W < 19) begin : g_chk
    $error("shs_standby_ctrl: parameter out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  shs_state_type state;
  shs_state_type next_state;
  logic [2:0] settle_code;
  logic osc_meta;
  logic osc_run;
  logic settle_done;
  logic settle_start;
  logic [4:0] settle_exp;
  logic [4:0] code_exp;
  logic [3:0] resume_cnt;
  logic resume_vec;
  logic wake;
  logic vec_req;
  logic sel_hit;
  logic sub_halt_main_off;
  logic main_halt_no_sub;

  // Exponent for a code; prohibited codes never reach the register
  function automatic logic [4:0] code_to_exp(input logic [2:0] code,
                                             input logic mode);
    logic [4:0] e;
    e = `SHS_EXP_CODE4;
    case (code)
      3'h0: e = `SHS_EXP_CODE0;
      3'h1: e = `SHS_EXP_CODE1;
      3'h2: e = `SHS_EXP_CODE2;
      3'h3: e = `SHS_EXP_CODE3;
      default: e = `SHS_EXP_CODE4;
    endcase
    if (!mode) begin
      e = e + `SHS_EXP_SLOW_ADD;
    end
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Oscillator-running synchroniser
  // ----------------------------------------------------------------
  // The analogue start flag is asynchronous to this clock; both stages
  // clear while the oscillator is off, so a one-cycle stop cannot leave
  // a stale running level that would count before the restart
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_meta <= 1'b0;
      osc_run <= 1'b0;
    end else begin
      osc_meta <= osc_running_i && main_osc_en_o;
      osc_run <= osc_meta && main_osc_en_o;
    end
  end

  // ----------------------------------------------------------------
  // Settle select register
  // ----------------------------------------------------------------
  assign sel_hit = (reg_addr_i == `SHS_SETTLE_ADDR);

  // Bit writes and prohibited codes are dropped, keeping the old code
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_code <= `SHS_SETTLE_RESET;
    end else if (reg_wr_i && sel_hit && !reg_bit_op_i) begin
      if (reg_wdata_i[2:0] <= `SHS_SETTLE_CODE_MAX &&
          reg_wdata_i[7:3] == 5'h00) begin
        settle_code <= reg_wdata_i[2:0];
      end
    end
  end

  // Read data; unmapped addresses and reserved bits read zero
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i && sel_hit) begin
      reg_rdata_o <= {5'h00, settle_code};
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  assign code_exp = code_to_exp(settle_code, osc_mode_bit_i);

  // Reset release uses a fixed exponent, not the reset code's one
  always_comb begin
    if (state == SHS_RST_SETTLE) begin
      settle_exp = `SHS_EXP_RESET - 5'(SETTLE_EXP_CUT);
    end else begin
      settle_exp = code_exp - 5'(SETTLE_EXP_CUT);
    end
  end

  assign settle_start = (state == SHS_STOP) && wake;

  shs_settle_counter #(
    .CNT_W(CNT_W)
  ) u_settle (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(settle_start),
    .osc_run_i(osc_run),
    .exp_i(settle_exp),
    .done_o(settle_done)
  );

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  // Deep mode wakes on maskable interrupts and test input only
  assign wake = irq_pending_i || test_input_i ||
                (nmi_pending_i && state == SHS_HALT);
  assign vec_req = nmi_pending_i || (irq_pending_i && irq_enable_i);

  always_comb begin
    next_state = state;
    case (state)
      SHS_RST_SETTLE: begin
        if (settle_done) begin
          next_state = SHS_RUN;
        end
      end
      SHS_RUN: begin
        if (halt_exec_i) begin
          next_state = SHS_HALT;
        end else if (stop_exec_i && !on_subclock_i) begin
          next_state = SHS_STOP;
        end
      end
      SHS_HALT: begin
        if (wake) begin
          next_state = SHS_RESUME;
        end
      end
      SHS_STOP: begin
        if (wake) begin
          next_state = SHS_SETTLE;
        end
      end
      SHS_SETTLE: begin
        if (settle_done) begin
          next_state = SHS_RUN;
        end
      end
      SHS_RESUME: begin
        if (resume_cnt == 4'h1) begin
          next_state = SHS_RUN;
        end
      end
      default: next_state = SHS_RUN;
    endcase
  end

  // Reset acts as a deep-mode release and waits for the oscillator
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= SHS_RST_SETTLE;
    end else begin
      state <= next_state;
    end
  end

  // Light-mode release wait, chosen by the kind of resumption
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_cnt <= 4'h0;
      resume_vec <= 1'b0;
    end else if (state == SHS_HALT && wake) begin
      resume_vec <= vec_req && !(test_input_i && !irq_pending_i &&
                                 !nmi_pending_i);
      resume_cnt <= vec_req ? `SHS_HALT_VEC_WAIT
                            : `SHS_HALT_NEXT_WAIT;
    end else if (state == SHS_STOP && wake) begin
      resume_vec <= irq_pending_i && irq_enable_i;
    end else if (state == SHS_RESUME && resume_cnt != 4'h0) begin
      resume_cnt <= resume_cnt - 4'h1;
    end
  end

  // Resume pulses mark the exact cycle the processor clock returns
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resume_vector_o <= 1'b0;
      resume_next_o <= 1'b0;
    end else begin
      resume_vector_o <= (state == SHS_RESUME || state == SHS_SETTLE) &&
                         next_state == SHS_RUN && resume_vec;
      resume_next_o <= (state == SHS_RESUME || state == SHS_SETTLE) &&
                       next_state == SHS_RUN && !resume_vec;
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and oscillator control
  // ----------------------------------------------------------------
  // Only the processor clock is gated; apart from the synchroniser stages,
  // which clear in deep mode, no register is cleared, so other state is held
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_clk_en_o <= 1'b0;
      main_osc_en_o <= 1'b1;
      sub_osc_en_o <= 1'b1;
      reset_hold_o <= 1'b1;
      standby_o <= 1'b0;
    end else begin
      cpu_clk_en_o <= (next_state == SHS_RUN);
      main_osc_en_o <= (next_state != SHS_STOP);
      sub_osc_en_o <= 1'b1;
      reset_hold_o <= (next_state == SHS_RST_SETTLE);
      standby_o <= (next_state != SHS_RUN) &&
                   (next_state != SHS_RST_SETTLE);
    end
  end

  // ----------------------------------------------------------------
  // Peripheral run permissions
  // ----------------------------------------------------------------
  assign main_halt_no_sub = !on_subclock_i && !sub_clk_present_i;
  assign sub_halt_main_off = on_subclock_i && main_osc_off_i;

  // Main clock stops in deep mode, so only subclock or pin-fed
  // functions may run there
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wt_run_o <= 1'b1;
      lcd_run_o <= 1'b1;
      tmr8_run_o <= 1'b1;
      tmr16_run_o <= 1'b1;
      sio_run_o <= 1'b1;
    end else if (next_state == SHS_HALT && main_halt_no_sub) begin
      wt_run_o <= wt_clk_main_div_i;
      lcd_run_o <= wt_clk_main_div_i;
      tmr8_run_o <= 1'b1;
      tmr16_run_o <= 1'b1;
      sio_run_o <= 1'b1;
    end else if (next_state == SHS_HALT && sub_halt_main_off) begin
      wt_run_o <= wt_clk_sub_i;
      lcd_run_o <= wt_clk_sub_i;
      tmr8_run_o <= tmr8_ext_clk_i;
      tmr16_run_o <= tmr16_wt_clk_i && wt_clk_sub_i;
      sio_run_o <= sio_ext_clk_i;
    end else if (next_state == SHS_STOP || next_state == SHS_SETTLE) begin
      wt_run_o <= wt_clk_sub_i && sub_clk_present_i;
      lcd_run_o <= wt_clk_sub_i && sub_clk_present_i;
      tmr8_run_o <= tmr8_ext_clk_i;
      tmr16_run_o <= tmr16_wt_clk_i && wt_clk_sub_i && sub_clk_present_i;
      sio_run_o <= sio_ext_clk_i;
    end else begin
      wt_run_o <= 1'b1;
      lcd_run_o <= 1'b1;
      tmr8_run_o <= 1'b1;
      tmr16_run_o <= 1'b1;
      sio_run_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- bench/shs_standby_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module shs_standby_ctrl_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic halt_exec_i,
  input wire logic stop_exec_i,
  input wire logic on_subclock_i,
  input wire logic main_osc_off_i,
  input wire logic sub_clk_present_i,
  input wire logic irq_pending_i,
  input wire logic irq_enable_i,
  input wire logic test_input_i,
  input wire logic wt_clk_main_div_i,
  input wire logic tmr8_ext_clk_i,
  input wire logic sio_ext_clk_i,
  input wire logic wt_clk_sub_i,
  input wire logic tmr16_wt_clk_i,
  input wire logic cpu_clk_en_o,
  input wire logic main_osc_en_o,
  input wire logic sub_osc_en_o,
  input wire logic reset_hold_o,
  input wire logic standby_o,
  input wire logic resume_vector_o,
  input wire logic resume_next_o,
  input wire logic wt_run_o,
  input wire logic lcd_run_o,
  input wire logic tmr8_run_o,
  input wire logic tmr16_run_o,
  input wire logic sio_run_o
);
  // ----------------------------------------------------------------
  // Standby entry and release checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Halt taken while the processor runs, then a maskable wake
  sequence s_halt;
    halt_exec_i && cpu_clk_en_o;
  endsequence
  sequence s_halt_irq;
    s_halt ##1 (irq_pending_i && !test_input_i);
  endsequence
  property p_halt_entry;
    s_halt |=> !cpu_clk_en_o && standby_o && main_osc_en_o;
  endproperty
  a_halt_entry: assert property (p_halt_entry)
    else $error("halt did not gate the processor clock");
  property p_stop_entry;
    stop_exec_i && !halt_exec_i && !on_subclock_i && cpu_clk_en_o
      |=> !main_osc_en_o && standby_o && sub_osc_en_o;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop did not halt the main oscillator");
  property p_stop_refused;
    stop_exec_i && !halt_exec_i && on_subclock_i && cpu_clk_en_o
      |=> cpu_clk_en_o && main_osc_en_o;
  endproperty
  a_stop_refused: assert property (p_stop_refused)
    else $error("stop taken while on the subsystem clock");
  property p_sub_osc;
    1'b1 |-> sub_osc_en_o;
  endproperty
  a_sub_osc: assert property (p_sub_osc)
    else $error("subsystem oscillator was stopped");
  property p_halt_vec;
    s_halt_irq ##0 irq_enable_i
      |=> !cpu_clk_en_o [*8] ##1 (cpu_clk_en_o && resume_vector_o);
  endproperty
  a_halt_vec: assert property (p_halt_vec)
    else $error("vectored halt release wait wrong");
  property p_halt_next;
    s_halt_irq ##0 !irq_enable_i
      |=> !cpu_clk_en_o [*2] ##1 (cpu_clk_en_o && resume_next_o);
  endproperty
  a_halt_next: assert property (p_halt_next)
    else $error("plain halt release wait wrong");
  property p_wake_stop;
    $rose(main_osc_en_o) |-> !cpu_clk_en_o [*4];
  endproperty
  a_wake_stop: assert property (p_wake_stop)
    else $error("processor clock back before oscillator settled");
  property p_resume_pulse;
    resume_vector_o || resume_next_o |-> cpu_clk_en_o && !$past(cpu_clk_en_o);
  endproperty
  a_resume_pulse: assert property (p_resume_pulse)
    else $error("resume pulse outside clock return");
  property p_hold;
    reset_hold_o |-> !cpu_clk_en_o && main_osc_en_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("processor clock ran during reset settle");
  property p_halt_main;
    s_halt ##0 (!on_subclock_i && !sub_clk_present_i) |=>
      wt_run_o == $past(wt_clk_main_div_i) &&
      lcd_run_o == $past(wt_clk_main_div_i);
  endproperty
  a_halt_main: assert property (p_halt_main)
    else $error("watch or display run wrong in main halt");
  property p_halt_sub;
    s_halt ##0 (on_subclock_i && main_osc_off_i) |=>
      tmr8_run_o == $past(tmr8_ext_clk_i) && sio_run_o == $past(sio_ext_clk_i);
  endproperty
  a_halt_sub: assert property (p_halt_sub)
    else $error("timer or serial run wrong in subclock halt");
  property p_halt_sub_watch;
    s_halt ##0 (on_subclock_i && main_osc_off_i) |=>
      wt_run_o == $past(wt_clk_sub_i) && lcd_run_o == $past(wt_clk_sub_i) &&
      tmr16_run_o == ($past(tmr16_wt_clk_i) && $past(wt_clk_sub_i));
  endproperty
  a_halt_sub_watch: assert property (p_halt_sub_watch)
    else $error("watch or 16-bit timer run wrong in subclock halt");
endmodule
bind shs_standby_ctrl shs_standby_ctrl_sva chk_u (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .halt_exec_i(halt_exec_i),
  .stop_exec_i(stop_exec_i), .on_subclock_i(on_subclock_i),
  .main_osc_off_i(main_osc_off_i), .sub_clk_present_i(sub_clk_present_i),
  .irq_pending_i(irq_pending_i), .irq_enable_i(irq_enable_i),
  .test_input_i(test_input_i), .wt_clk_main_div_i(wt_clk_main_div_i),
  .tmr8_ext_clk_i(tmr8_ext_clk_i), .sio_ext_clk_i(sio_ext_clk_i),
  .cpu_clk_en_o(cpu_clk_en_o), .main_osc_en_o(main_osc_en_o),
  .sub_osc_en_o(sub_osc_en_o), .reset_hold_o(reset_hold_o),
  .standby_o(standby_o), .resume_vector_o(resume_vector_o),
  .resume_next_o(resume_next_o), .wt_run_o(wt_run_o), .lcd_run_o(lcd_run_o),
  .tmr8_run_o(tmr8_run_o), .sio_run_o(sio_run_o),
  .wt_clk_sub_i(wt_clk_sub_i), .tmr16_wt_clk_i(tmr16_wt_clk_i),
  .tmr16_run_o(tmr16_run_o));
`default_nettype wire

//--- bench/shs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module shs_core_model #(
  parameter int OSC_START = 3
) (
  input wire logic sys_clk_i,
  input wire logic main_osc_en_i,
  output logic osc_running_o,
  output logic halt_exec_o = 1'b0,
  output logic stop_exec_o = 1'b0
);
  // ----------------------------------------------------------------
  // Oscillator start-up and instruction strobes
  // ----------------------------------------------------------------
  int start_cnt = 0;
  // Start-up gap is real but must not be counted as settle time
  always @(posedge sys_clk_i) begin
    if (!main_osc_en_i) begin
      start_cnt <= 0;
    end else if (start_cnt < OSC_START) begin
      start_cnt <= start_cnt + 1;
    end
  end
  assign osc_running_o = main_osc_en_i && (start_cnt == OSC_START);
  // One-cycle strobe; software has idled peripherals and converter first
  task automatic exec(input logic stop);
    @(posedge sys_clk_i);
    halt_exec_o <= !stop;
    stop_exec_o <= stop;
    @(posedge sys_clk_i);
    halt_exec_o <= 1'b0;
    stop_exec_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- bench/shs_standby_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module shs_standby_ctrl_tb;
  localparam int CUT = 10;
  localparam int OSC = 3;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_wr_i = 1'b0, reg_bit_op_i = 1'b0, reg_rd_i = 1'b0;
  logic halt_exec_i, stop_exec_i, osc_running_i;
  logic on_subclock_i = 1'b0, main_osc_off_i = 1'b0, sub_clk_present_i = 1'b1;
  logic osc_mode_bit_i = 1'b0, irq_pending_i = 1'b0, nmi_pending_i = 1'b0;
  logic irq_enable_i = 1'b0, test_input_i = 1'b0;
  logic [4:0] pclk = 5'h1f;
  logic cpu_clk_en_o, main_osc_en_o, sub_osc_en_o, reset_hold_o, standby_o;
  logic resume_vector_o, resume_next_o, wt_run_o, lcd_run_o, tmr8_run_o;
  logic tmr16_run_o, sio_run_o;
  int err_count = 0;
  int comparisons = 0;
  int n;
  logic [31:0] seed = 32'h9270067a;
  always #50 sys_clk_i = ~sys_clk_i;
  shs_standby_ctrl #(.SETTLE_EXP_CUT(CUT)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_bit_op_i(reg_bit_op_i), .reg_rdata_o(reg_rdata_o),
    .halt_exec_i(halt_exec_i), .stop_exec_i(stop_exec_i),
    .on_subclock_i(on_subclock_i), .main_osc_off_i(main_osc_off_i),
    .sub_clk_present_i(sub_clk_present_i), .osc_mode_bit_i(osc_mode_bit_i),
    .osc_running_i(osc_running_i), .irq_pending_i(irq_pending_i),
    .nmi_pending_i(nmi_pending_i), .irq_enable_i(irq_enable_i),
    .test_input_i(test_input_i), .wt_clk_main_div_i(pclk[0]),
    .wt_clk_sub_i(pclk[1]), .tmr8_ext_clk_i(pclk[2]),
    .tmr16_wt_clk_i(pclk[3]), .sio_ext_clk_i(pclk[4]),
    .cpu_clk_en_o(cpu_clk_en_o), .main_osc_en_o(main_osc_en_o),
    .sub_osc_en_o(sub_osc_en_o), .reset_hold_o(reset_hold_o),
    .standby_o(standby_o), .resume_vector_o(resume_vector_o),
    .resume_next_o(resume_next_o), .wt_run_o(wt_run_o), .lcd_run_o(lcd_run_o),
    .tmr8_run_o(tmr8_run_o), .tmr16_run_o(tmr16_run_o), .sio_run_o(sio_run_o));
  shs_core_model #(.OSC_START(OSC)) core_u (
    .sys_clk_i(sys_clk_i), .main_osc_en_i(main_osc_en_o),
    .osc_running_o(osc_running_i), .halt_exec_o(halt_exec_i),
    .stop_exec_o(stop_exec_i));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Settle cycles for a code; mode bit clear doubles the wait
  function automatic int settle_len(input logic [2:0] c, input logic m);
    int e;
    e = (c == 3'h0) ? 12 : 13 + int'(c);
    return 1 << (e + (m ? 0 : 1) - CUT);
  endfunction
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask
  // Start-up gap and sync stages make the exact figure slightly loose
  task automatic check_span(input string what, input int lo, input int got);
    comparisons++;
    if (got < lo || got > lo + OSC + 8) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", what, lo, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] d, input logic bitop);
    @(posedge sys_clk_i);
    reg_addr_i <= 16'hfffa;
    reg_wdata_i <= d;
    reg_bit_op_i <= bitop;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    check("read data", exp, reg_rdata_o);
  endtask
  // Bounded wait for the processor clock, counted in cycles
  // First look is a falling edge, so a clock enable about to drop at
  // this very edge is never mistaken for a finished wait
  task automatic wait_run(output int k);
    k = 0;
    do begin
      @(negedge sys_clk_i);
      k++;
    end while (cpu_clk_en_o !== 1'b1 && k < 2000);
  endtask
  task automatic wake(input logic en, input logic tst);
    irq_enable_i <= en;
    irq_pending_i <= !tst;
    test_input_i <= tst;
    wait_run(n);
  endtask
  task automatic release_wake();
    @(posedge sys_clk_i);
    irq_pending_i <= 1'b0;
    test_input_i <= 1'b0;
    nmi_pending_i <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    $display("unexpected run length: expected finish, seen hang");
    results();
  end
  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_run(n);
    check_span("reset settle", 1 << (17 - CUT), n);
    reg_read(16'hfffa, 8'h04);
    reg_write(8'h01, 1'b1);
    reg_write(8'h07, 1'b0);
    reg_read(16'hfffa, 8'h04);
    reg_read(16'hfffb, 8'h00);
    // Every code in both oscillator modes, wake source drawn at random
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      reg_write({5'h00, 3'(i % 5)}, 1'b0);
      osc_mode_bit_i <= (i >= 5);
      pclk <= seed[6:2];
      core_u.exec(1'b1);
      repeat (5) @(negedge sys_clk_i);
      check("osc enable in stop", 8'h00, {7'h00, main_osc_en_o});
      check("run permits in stop",
            {3'h0, pclk[1], pclk[1], pclk[2], pclk[3] & pclk[1], pclk[4]},
            {3'h0, wt_run_o, lcd_run_o, tmr8_run_o, tmr16_run_o,
             sio_run_o});
      @(posedge sys_clk_i);
      wake(seed[1], seed[0]);
      check_span("stop settle", settle_len(3'(i % 5), i >= 5),
                 n);
      check("stop resume kind",
            {6'h00, seed[1] & !seed[0], !seed[1] | seed[0]},
            {6'h00, resume_vector_o, resume_next_o});
      release_wake();
      reg_read(16'hfffa, {5'h00, 3'(i % 5)});
    end
    // Halt release with random clock context and peripheral selects
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      @(posedge sys_clk_i);
      pclk <= seed[4:0];
      on_subclock_i <= seed[5];
      main_osc_off_i <= seed[5];
      sub_clk_present_i <= seed[6];
      // Non-maskable request vectors even with interrupts disabled
      nmi_pending_i <= (i == 6);
      core_u.exec(1'b0);
      wake(i[0], i[2:1] == 2'h3);
      check("halt release wait",
            8'(((i[0] && i[2:1] != 2'h3) || i == 6) ? 10 : 4),
            8'(n));
      release_wake();
    end
    on_subclock_i <= 1'b1;
    core_u.exec(1'b1);
    repeat (3) @(negedge sys_clk_i);
    check("clock after refused stop", 8'h01, {7'h00, cpu_clk_en_o});
    results();
  end
endmodule
`default_nettype wire
